// ===== design/io_ports_pkg.sv
// constants shared by the address-shared port logic
package io_ports_pkg;

    // register byte offsets on the wishbone slave
    localparam int unsigned ADDR_W                 = 8;
    localparam logic [7:0]  OFF_PORT1_DIRECTION    = 8'h00;
    localparam logic [7:0]  OFF_PORT1_DATA         = 8'h04;
    localparam logic [7:0]  OFF_PORT6_DIRECTION    = 8'h08;
    localparam logic [7:0]  OFF_PORT6_OUTPUT_DATA  = 8'h0C;
    localparam logic [7:0]  OFF_MODULE_STOP_HIGH   = 8'h10;
    localparam logic [7:0]  OFF_MODE_STATUS        = 8'h14;

    // field positions
    localparam int unsigned CLOCK_PIN_STOP_POS     = 0;
    localparam int unsigned PORT6_TOP_POS          = 7;

    // reset values, and the fixed port-six direction readback
    localparam logic [7:0]  PORT1_DIRECTION_RESET  = 8'h00;
    localparam logic [7:0]  PORT1_DATA_RESET       = 8'h00;
    localparam logic [7:0]  PORT6_DIRECTION_RESET  = 8'h80;
    localparam logic [7:0]  PORT6_DATA_RESET       = 8'h80;
    localparam logic [7:0]  PORT6_DIRECTION_READ   = 8'hFF;
    localparam logic        CLOCK_PIN_STOP_RESET   = 1'b0;

    // operating mode numbers sampled from the mode pins
    localparam logic [2:0]  MODE_EXP_ROM_OFF_FIRST = 3'h1;
    localparam logic [2:0]  MODE_EXP_ROM_OFF_LAST  = 3'h4;
    localparam logic [2:0]  MODE_EXP_ROM_ON        = 3'h5;
    localparam logic [2:0]  MODE_RESET             = 3'h7;

    // how port-one pins are shared with the address bus
    typedef enum logic [1:0] {
        PIN_USE_GPIO     = 2'b00,
        PIN_USE_PER_BIT  = 2'b01,
        PIN_USE_ADDRESS  = 2'b11
    } pin_use_type;

endpackage

// ===== design/port_pin_mux.sv
// per-pin output, enable and readback selection for one port
`timescale 1ns/1ps

module port_pin_mux #(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic [WIDTH-1:0] direction_i,
    input  wire logic [WIDTH-1:0] data_i,
    input  wire logic [WIDTH-1:0] pin_level_i,
    input  wire logic [WIDTH-1:0] address_sel_i,
    input  wire logic [WIDTH-1:0] address_i,
    output logic      [WIDTH-1:0] out_level_o,
    output logic      [WIDTH-1:0] out_enable_o,
    output logic      [WIDTH-1:0] read_value_o
);

    // the address function wins over the port data on every pin it owns
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            out_level_o[i]  = address_sel_i[i] ? address_i[i] : data_i[i];
            out_enable_o[i] = address_sel_i[i] | direction_i[i];
            read_value_o[i] = direction_i[i] ? data_i[i] : pin_level_i[i];
        end
    end

endmodule

// ===== design/address_shared_io_ports.sv
// address-shared port one and general port six with a wishbone register slave
//
// Notes on behaviour
// RQ1 - modes one to four: all port-one pins drive the low address lines.
// RQ2 - mode five: port-one pin is address output if direction set, else input.
// RQ3 - single-chip modes: port-one pins are plain I/O under their direction bits.
// RQ4 - during DRAM cycles the low address pins carry multiplexed row/column addresses.
// RQ5 - port-six pin drives when its direction bit is one, else it is an input; the top pin instead drives unless the clock pin is stopped.
// RQ6 - port-six direction register is write-only and reads back all ones.
// RQ7 - port-six direction resets to 0x80 on reset/hardware standby, kept in software standby.
// RQ8 - port-six outputs keep their level throughout software standby.
// RQ9 - a port-six output pin carries the matching output data bit; the top pin carries the clock level instead.
// RQ10 - data bit seven ignores writes; reads one, or the top pin when clock stopped.
// RQ11 - low seven data bits read pin level if direction zero, stored value if one.
// RQ12 - port-six data resets to 0x80 on reset/hardware standby, kept in software standby.
// RQ13 - address output takes precedence over the port function on pins the mode assigns.
`timescale 1ns/1ps

module address_shared_io_ports
    import io_ports_pkg::*;
#(
    parameter int unsigned PORT_W = 8
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // classic wishbone slave
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [io_ports_pkg::ADDR_W-1:0] adr_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [31:0]                   dat_i,
    output logic      [31:0]                   dat_o,
    output logic                               ack_o,
    // chip state
    input  wire logic [2:0]                    mode_i,
    input  wire logic                          hw_standby_i,
    input  wire logic                          sw_standby_i,
    // external memory bus from the bus controller
    input  wire logic [PORT_W-1:0]             low_address_lines_i,
    input  wire logic                          dram_cycle_i,
    input  wire logic [PORT_W-1:0]             dram_mux_address_i,
    // system clock level offered on the top port-six pin
    input  wire logic                          clock_pin_level_i,
    // port one pins
    input  wire logic [PORT_W-1:0]             port1_pin_i,
    output logic      [PORT_W-1:0]             port1_pin_o,
    output logic      [PORT_W-1:0]             port1_pin_oe_o,
    // port six pins
    input  wire logic [PORT_W-1:0]             port6_pin_i,
    output logic      [PORT_W-1:0]             port6_pin_o,
    output logic      [PORT_W-1:0]             port6_pin_oe_o
);

    import io_ports_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        // software-visible registers
        logic [PORT_W-1:0] port1_direction_reg;
        logic [PORT_W-1:0] port1_data;
        logic [PORT_W-1:0] port6_direction;
        logic [PORT_W-1:0] port6_output_data;
        logic              clock_pin_stop_bit;
        // operating mode, sampled so the pin sharing never follows a glitching mode input
        logic [2:0]        mode;
        // bus answer
        logic              ack;
        logic [31:0]       rdata;
        // registered pin drive, frozen as a whole in software standby
        logic [PORT_W-1:0] p1_out;
        logic [PORT_W-1:0] p1_oe;
        logic [PORT_W-1:0] p6_out;
        logic [PORT_W-1:0] p6_oe;
    } state_type;

    // reset and hardware standby both load this; software standby never does
    localparam state_type STATE_RESET = '{
        port1_direction_reg: PORT1_DIRECTION_RESET,
        port1_data:          PORT1_DATA_RESET,
        port6_direction:     PORT6_DIRECTION_RESET,
        port6_output_data:   PORT6_DATA_RESET,
        clock_pin_stop_bit:  CLOCK_PIN_STOP_RESET,
        mode:                MODE_RESET,
        ack:                 1'b0,
        rdata:               32'h0000_0000,
        p1_out:              '0,
        p1_oe:               '0,
        p6_out:              '0,
        p6_oe:               '0
    };

    state_type state_reg;
    state_type state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // local signals

    // port-one sharing with the address bus
    pin_use_type       port1_use;
    logic [PORT_W-1:0] port1_addr_sel;
    logic [PORT_W-1:0] port1_addr_val;
    logic [PORT_W-1:0] port1_out_w;
    logic [PORT_W-1:0] port1_oe_w;
    logic [PORT_W-1:0] port1_rd_w;
    // port-six paths for the low seven pins; the top pin is handled apart
    logic [PORT_W-2:0] port6_out_w;
    logic [PORT_W-2:0] port6_oe_w;
    logic [PORT_W-2:0] port6_rd_w;
    logic              port6_top_read;
    logic [PORT_W-1:0] port6_read_value;
    // bus decode
    logic              bus_hit;
    logic              bus_write;
    logic [7:0]        bus_offset;

    ////////////////////////////////////////////////////////////////////////////////
    // port-one pin ownership from the sampled operating mode

    // modes below the first expanded mode are reserved and treated as single-chip
    // the pins follow a mode change two edges late, so nothing may rely on the first cycle after it
    always_comb begin
        if (state_reg.mode >= MODE_EXP_ROM_OFF_FIRST && state_reg.mode <= MODE_EXP_ROM_OFF_LAST) begin
            port1_use = PIN_USE_ADDRESS;                                   // see RQ1
        end else if (state_reg.mode == MODE_EXP_ROM_ON) begin
            port1_use = PIN_USE_PER_BIT;                                   // see RQ2
        end else begin
            port1_use = PIN_USE_GPIO;                                      // see RQ3
        end
    end

    // the address function overrides the port data wherever the mode hands a pin to it
    // in mode five the direction bits double as the address-pin selection
    always_comb begin
        case (port1_use)
            PIN_USE_ADDRESS: port1_addr_sel = '1;                          // see RQ13
            PIN_USE_PER_BIT: port1_addr_sel = state_reg.port1_direction_reg; // see RQ2
            PIN_USE_GPIO:    port1_addr_sel = '0;                          // see RQ3
            default:         port1_addr_sel = '0;
        endcase
    end

    // dram cycles put the row/column multiplexed address on the low lines
    // the bus controller owns the timing; this block only routes the value to the pins
    assign port1_addr_val = dram_cycle_i ? dram_mux_address_i : low_address_lines_i; // see RQ4

    ////////////////////////////////////////////////////////////////////////////////
    // pin muxes

    // direction is the output enable, and the address overlay rides on address_sel_i
    port_pin_mux #(
        .WIDTH (PORT_W)
    ) port1_mux (
        .direction_i   (state_reg.port1_direction_reg),
        .data_i        (state_reg.port1_data),
        .pin_level_i   (port1_pin_i),
        .address_sel_i (port1_addr_sel),
        .address_i     (port1_addr_val),
        .out_level_o   (port1_out_w),
        .out_enable_o  (port1_oe_w),
        .read_value_o  (port1_rd_w)
    );

    // port six has no address function; its top pin is handled apart
    // its address inputs are tied off, so the mux reduces to plain direction control
    port_pin_mux #(
        .WIDTH (PORT_W - 1)
    ) port6_mux (
        .direction_i   (state_reg.port6_direction[PORT_W-2:0]),
        .data_i        (state_reg.port6_output_data[PORT_W-2:0]),
        .pin_level_i   (port6_pin_i[PORT_W-2:0]),
        .address_sel_i ('0),
        .address_i     ('0),
        .out_level_o   (port6_out_w),
        .out_enable_o  (port6_oe_w),
        .read_value_o  (port6_rd_w)
    );

    // top bit reads one unless the clock pin is stopped, then it is the live pin;
    // the stored top data bit is never consulted, so a write to it has no effect
    always_comb begin
        if (state_reg.clock_pin_stop_bit) begin
            port6_top_read = port6_pin_i[PORT6_TOP_POS];                   // see RQ10
        end else begin
            port6_top_read = 1'b1;                                         // see RQ10
        end
    end

    // low bits come from the mux: live pin where an input, stored value where an output
    assign port6_read_value = {port6_top_read, port6_rd_w};               // see RQ11

    ////////////////////////////////////////////////////////////////////////////////
    // wishbone decode

    // ack is held off for one cycle after it is given so a held request is taken once
    // only byte lane zero is decoded; the upper lanes of a wider access are dropped
    // unmapped offsets still answer so a stray access never hangs the master
    assign bus_hit    = cyc_i & stb_i & ~state_reg.ack;
    assign bus_write  = bus_hit & we_i & sel_i[0];
    assign bus_offset = adr_i[7:0];

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        // defaults: hold every register, sample the mode, answer a fresh request
        state_next       = state_reg;
        state_next.mode  = mode_i;
        state_next.ack   = bus_hit;

        // register writes; only byte lane zero carries data
        if (bus_write) begin
            case (bus_offset)
                OFF_PORT1_DIRECTION: begin
                    // in mode five these bits also choose which pins carry the address
                    state_next.port1_direction_reg = dat_i[PORT_W-1:0];
                end
                OFF_PORT1_DATA: begin
                    state_next.port1_data = dat_i[PORT_W-1:0];
                end
                OFF_PORT6_DIRECTION: begin
                    // top direction bit has no pin function and keeps its reset value
                    state_next.port6_direction[PORT_W-2:0] = dat_i[PORT_W-2:0]; // see RQ5
                end
                OFF_PORT6_OUTPUT_DATA: begin
                    state_next.port6_output_data[PORT_W-2:0] = dat_i[PORT_W-2:0]; // see RQ10
                end
                OFF_MODULE_STOP_HIGH: begin
                    // stopping the clock pin hands the top port-six pin back as an input
                    state_next.clock_pin_stop_bit = dat_i[CLOCK_PIN_STOP_POS];
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end

        // register reads; unmapped offsets answer with zero
        if (bus_hit && !we_i) begin
            case (bus_offset)
                OFF_PORT1_DIRECTION: begin
                    state_next.rdata = {24'h0000_00, state_reg.port1_direction_reg};
                end
                OFF_PORT1_DATA: begin
                    // input pins read back live, output pins their stored bit
                    state_next.rdata = {24'h0000_00, port1_rd_w};
                end
                OFF_PORT6_DIRECTION: begin
                    state_next.rdata = {24'h0000_00, PORT6_DIRECTION_READ}; // see RQ6
                end
                OFF_PORT6_OUTPUT_DATA: begin
                    state_next.rdata = {24'h0000_00, port6_read_value};   // see RQ11
                end
                OFF_MODULE_STOP_HIGH: begin
                    state_next.rdata = {31'h0000_0000, state_reg.clock_pin_stop_bit};
                end
                OFF_MODE_STATUS: begin
                    // lets software see which sharing the port-one pins are under
                    state_next.rdata = {29'h0000_0000, state_reg.mode};
                end
                default: begin
                    state_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        // pins freeze in software standby so outputs keep their level
        // freezing the drive rather than the registers keeps the registers writable meanwhile
        if (!sw_standby_i) begin                                           // see RQ8
            state_next.p1_out = port1_out_w;
            state_next.p1_oe  = port1_oe_w;
            state_next.p6_out = {clock_pin_level_i, port6_out_w};          // see RQ9
            // top pin carries the clock while it is not stopped
            state_next.p6_oe  = {~state_reg.clock_pin_stop_bit, port6_oe_w}; // see RQ5
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register

    // hardware standby initialises like reset; software standby touches nothing
    // a synchronous reset keeps the whole state in one clocked process, at the cost of needing a live clock
    always_ff @(posedge clk_i) begin
        if (rst_i || hw_standby_i) begin
            state_reg <= STATE_RESET;                                      // see RQ7 see RQ12
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register

    // every output is a flip-flop, so the pins never glitch while the muxes settle
    assign dat_o          = state_reg.rdata;
    assign ack_o          = state_reg.ack;
    assign port1_pin_o    = state_reg.p1_out;
    assign port1_pin_oe_o = state_reg.p1_oe;
    assign port6_pin_o    = state_reg.p6_out;
    assign port6_pin_oe_o = state_reg.p6_oe;

endmodule

// ===== verification/pin_partner.sv
// external pin model standing on the far side of one eight-bit port
`timescale 1ns/1ps
module pin_partner (
    input  wire logic [7:0] drive_i,
    input  wire logic [7:0] enable_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] pin_o
);
    // a released pin shows the outside driver's level, never the stale port value
    assign pin_o = (drive_i & enable_i) | (ext_i & ~enable_i);
endmodule

// ===== verification/io_ports_assertions.sv
// concurrent checks on the port block's bus handshake and pin behaviour
`timescale 1ns/1ps
module io_ports_checker
    import io_ports_pkg::*;
#(
    parameter int unsigned PORT_W = 8
) (
    input wire logic                            clk_i,
    input wire logic                            rst_i,
    input wire logic                            cyc_i,
    input wire logic                            stb_i,
    input wire logic                            we_i,
    input wire logic [io_ports_pkg::ADDR_W-1:0] adr_i,
    input wire logic [31:0]                     dat_o,
    input wire logic                            ack_o,
    input wire logic [2:0]                      mode_i,
    input wire logic                            hw_standby_i,
    input wire logic                            sw_standby_i,
    input wire logic [PORT_W-1:0]               low_address_lines_i,
    input wire logic                            dram_cycle_i,
    input wire logic [PORT_W-1:0]               dram_mux_address_i,
    input wire logic [PORT_W-1:0]               port1_pin_o,
    input wire logic [PORT_W-1:0]               port1_pin_oe_o,
    input wire logic [PORT_W-1:0]               port6_pin_i,
    input wire logic [PORT_W-1:0]               port6_pin_o,
    input wire logic [PORT_W-1:0]               port6_pin_oe_o
);
    ////////////////////////////////////////////////////////////////
    // address offered to the low pins, and a request not yet answered
    wire [PORT_W-1:0] bus_addr = dram_cycle_i ? dram_mux_address_i : low_address_lines_i;
    wire              req      = cyc_i && stb_i && !ack_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || hw_standby_i);
    // mode held two edges, since the mode register adds one edge before the pins
    sequence rom_off_seq;
        (mode_i >= MODE_EXP_ROM_OFF_FIRST && mode_i <= MODE_EXP_ROM_OFF_LAST && !sw_standby_i) [*2];
    endsequence
    sequence rom_on_seq;
        (mode_i == MODE_EXP_ROM_ON && !sw_standby_i) [*2];
    endsequence
    a_ack_answer: assert property (req |=> ack_o ##1 !ack_o)
        else $error("bus request not answered by one ack pulse");
    a_dir_ones: assert property (req && !we_i && adr_i == OFF_PORT6_DIRECTION |=> dat_o[7:0] == 8'hFF)
        else $error("direction read not all ones");
    a_rom_off_oe: assert property (rom_off_seq |=> port1_pin_oe_o == '1)
        else $error("port one not all driven in address mode");
    a_rom_off_addr: assert property (rom_off_seq |=> port1_pin_o == $past(bus_addr))
        else $error("port one does not carry the address");
    a_rom_on_addr: assert property (rom_on_seq |=> ((port1_pin_o ^ $past(bus_addr)) & port1_pin_oe_o) == '0)
        else $error("driven port one pin not carrying the address");
    a_standby_hold: assert property (sw_standby_i |=> $stable(port6_pin_o) && $stable(port6_pin_oe_o))
        else $error("port six pins moved in software standby");
    a_reset_pins: assert property (disable iff (1'b0)
        rst_i ##1 (!rst_i && !hw_standby_i && !sw_standby_i) |=> port6_pin_oe_o == 8'h80 && port6_pin_o[6:0] == '0)
        else $error("port six pins wrong after reset");
    a_top_read: assert property (req && !we_i && adr_i == OFF_PORT6_OUTPUT_DATA && port6_pin_i[7] |=> dat_o[7])
        else $error("top data bit read low with pin high");
endmodule
bind address_shared_io_ports io_ports_checker #(.PORT_W(PORT_W)) u_checker (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .mode_i, .hw_standby_i, .sw_standby_i,
    .low_address_lines_i, .dram_cycle_i, .dram_mux_address_i, .port1_pin_o, .port1_pin_oe_o,
    .port6_pin_i, .port6_pin_o, .port6_pin_oe_o
);

// ===== verification/address_shared_io_ports_bench.sv
// randomised self-checking bench for the address-shared port block
`timescale 1ns/1ps
module address_shared_io_ports_bench;
    import io_ports_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, dram_cycle_i = 0;
    logic        hw_standby_i = 0, sw_standby_i = 0, clock_pin_level_i = 0;
    logic [7:0]  adr_i = 0, low_address_lines_i = 0, dram_mux_address_i = 0, ext1 = 0, ext6 = 0;
    logic [7:0]  d, v, e, a, q;
    logic [7:0]  keep [2];
    logic [3:0]  sel_i = 0;
    logic [2:0]  mode_i = 3'h6;
    logic [31:0] dat_i = 0;
    wire  [31:0] dat_o;
    wire         ack_o;
    wire  [7:0]  port1_pin_i, port1_pin_o, port1_pin_oe_o, port6_pin_i, port6_pin_o, port6_pin_oe_o;
    integer      seed = 32'h4f64_1e2e;
    int          error_cnt = 0, num_checks = 0;

    address_shared_io_ports u_dut (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .mode_i,
        .hw_standby_i, .sw_standby_i, .low_address_lines_i, .dram_cycle_i, .dram_mux_address_i,
        .clock_pin_level_i, .port1_pin_i, .port1_pin_o, .port1_pin_oe_o, .port6_pin_i, .port6_pin_o,
        .port6_pin_oe_o
    );
    pin_partner u_pins1 (.drive_i(port1_pin_o), .enable_i(port1_pin_oe_o), .ext_i(ext1), .pin_o(port1_pin_i));
    pin_partner u_pins6 (.drive_i(port6_pin_o), .enable_i(port6_pin_oe_o), .ext_i(ext6), .pin_o(port6_pin_i));

    ////////////////////////////////////////////////////////////////
    // system clock, and a toggling level for the clock pin
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        clock_pin_level_i <= ~clock_pin_level_i;
    end
    function automatic logic [7:0] rnd();
        return 8'($random(seed));
    endfunction
    // port-six readback: top bit one while the clock pin runs, low bits per direction
    function automatic logic [7:0] p6_read(input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] pin);
        return {1'b1, (pin[6:0] & ~dir[6:0]) | (dat[6:0] & dir[6:0])};
    endfunction
    task check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task wcyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one classic cycle; request held until ack is sampled, only the watchdog ends a hung wait
    task bus(input logic w, input logic [7:0] ad, input logic [7:0] wd);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, ad, 24'h00_0000, wd, 4'h1};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o[7:0];
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task wr(input logic [7:0] ad, input logic [7:0] wd);
        bus(1'b1, ad, wd);
    endtask
    task rd(input logic [7:0] ad, input logic [7:0] exp);
        bus(1'b0, ad, 8'h00);
        check(q, exp);
    endtask
    task stop_test();
        if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        ext6 <= rnd();
        wcyc(2);
        rd(OFF_PORT6_DIRECTION, 8'hFF);
        rd(OFF_PORT6_OUTPUT_DATA, p6_read(8'h00, 8'h00, ext6));
        rd(8'h18, 8'h00);
        check(port6_pin_oe_o, 8'h80);
        // single-chip ports, all-out and all-in first, then random
        for (int i = 0; i < 8; i++) begin
            d = i == 0 ? 8'hFF : i == 1 ? 8'h00 : rnd();
            v = rnd();
            ext1 <= rnd();
            ext6 <= rnd();
            wr(OFF_PORT1_DIRECTION, d);
            wr(OFF_PORT1_DATA, v);
            wr(OFF_PORT6_DIRECTION, d);
            wr(OFF_PORT6_OUTPUT_DATA, v);
            wcyc(2);
            check(port1_pin_oe_o, d);
            check(port1_pin_o & d, v & d);
            check(port6_pin_oe_o, {1'b1, d[6:0]});
            check(port6_pin_o & {1'b0, d[6:0]}, v & {1'b0, d[6:0]});
            rd(OFF_PORT6_OUTPUT_DATA, p6_read(d, v, ext6));
            rd(OFF_PORT1_DATA, (ext1 & ~d) | (v & d));
            rd(OFF_PORT1_DIRECTION, d);
        end
        // clock pin released: top data bit follows the live pin, writes to it ignored
        wr(OFF_MODULE_STOP_HIGH, 8'h01);
        wr(OFF_PORT6_OUTPUT_DATA, 8'h00);
        for (int b = 0; b < 2; b++) begin
            e = rnd();
            e[7] = b[0];
            ext6 <= e;
            wcyc(2);
            check(port6_pin_oe_o & 8'h80, 8'h00);
            rd(OFF_PORT6_OUTPUT_DATA, {e[7], e[6:0] & ~d[6:0]});
        end
        wr(OFF_MODULE_STOP_HIGH, 8'h00);
        // expanded modes: the address bus takes pins over the port function
        wr(OFF_PORT1_DIRECTION, 8'h3C);
        for (int m = 1; m <= 5; m++) begin
            mode_i <= 3'(m);
            low_address_lines_i <= rnd();
            dram_mux_address_i <= rnd();
            dram_cycle_i <= m[0];
            wcyc(3);
            a = dram_cycle_i ? dram_mux_address_i : low_address_lines_i;
            e = m == 5 ? 8'h3C : 8'hFF;
            check(port1_pin_oe_o, e);
            check(port1_pin_o & e, a & e);
            rd(OFF_MODE_STATUS, 8'(m));
        end
        // software standby: port six frozen while the inputs behind it move
        sw_standby_i <= 1;
        wcyc(2);
        keep = '{port6_pin_o, port6_pin_oe_o};
        ext6 <= ~ext6;
        // stopping the clock pin would release the top pin, were the drive not frozen
        wr(OFF_MODULE_STOP_HIGH, 8'h01);
        wcyc(4);
        check(port6_pin_o, keep[0]);
        check(port6_pin_oe_o, keep[1]);
        wr(OFF_MODULE_STOP_HIGH, 8'h00);
        sw_standby_i <= 0;
        wcyc(2);
        rd(OFF_PORT6_OUTPUT_DATA, p6_read(d, 8'h00, ext6));
        // hardware standby returns both port-six registers to 0x80 like a reset
        hw_standby_i <= 1;
        wcyc(2);
        hw_standby_i <= 0;
        wcyc(2);
        check(port6_pin_oe_o, 8'h80);
        rd(OFF_PORT6_OUTPUT_DATA, p6_read(8'h00, 8'h00, ext6));
        stop_test();
    end
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        stop_test();
    end
endmodule
